/* logic/hbf_ctrl.sv */
// controller for a half-bridge gate driver: start-up sequence, gate commands,
// hard shutdown over the shared open-drain line and fault clear pulses.
// assumes the driver pins are asynchronous, the shutdown line is wired-or with
// a pull-up, and the supply-good pin reports settled supplies.
// Functional notes
// - pulling shutdown line low forces gates off
// - shutdown line is wired-or, active low
// - no fault clear while sync line low; only the start of a normal-mode clear pulse checks it
// - never hold fault clear permanently high
// - hold fault clear high until supplies settle
// - bootstrap order: clear, low pulse, release
// - low and clear pulses at least 15 us
`timescale 1ns/100ps
`include "hbf_params.svh"
module hbf_ctrl #(
    parameter int PULSE_CYCLES = `HBF_PULSE_CYCLES
) (
    input  wire logic          sys_clk,
    input  wire logic          sys_rst,
    input  wire logic          user_high,
    input  wire logic          user_low,
    input  wire logic          user_shutdown,
    input  wire logic          user_clear,
    output hbf_pkg::hbf_status_t status,
    output hbf_pkg::hbf_pins_t drv_pins,
    input  wire logic          supply_ok_pin,
    input  wire logic          sync_fault_in,
    input  wire logic          fault_shutdown_in,
    output logic               fault_shutdown_out,
    output logic               fault_shutdown_oe
);
    import hbf_pkg::*;

    localparam logic [`HBF_TIMER_W-1:0] PULSE_LAST = `HBF_TIMER_W'(PULSE_CYCLES - 1);

    hbf_state_t                state;
    logic [`HBF_TIMER_W-1:0]   timer;
    logic [`HBF_IN_COUNT-1:0]  pins_s;
    logic                      supply_s;
    logic                      sync_s;
    logic                      fsd_s;
    logic                      clear_pend;

    // every pin input passes two flops before any logic reads it; the supply pin
    // goes in inverted so the all-ones reset reads as not settled, else start-up
    // would leave the supply wait on the first edge after reset
    hbf_sync #(
        .W (`HBF_IN_COUNT)
    ) u_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .async_in ({fault_shutdown_in, sync_fault_in, ~supply_ok_pin}),
        .sync_out (pins_s)
    );

    assign supply_s = ~pins_s[`HBF_IN_SUPPLY]; // undo the inversion at the synchroniser
    assign sync_s   = pins_s[`HBF_IN_SYNC];
    assign fsd_s    = pins_s[`HBF_IN_FSD];

    // open-drain shutdown: data is always low and only the enable moves,
    // so peers on the net stay free
    always_ff @(posedge sys_clk)
    begin
        fault_shutdown_out <= 1'b0;
    end

    // shutdown request drives the shared line; registered so the pin is glitch-free
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            fault_shutdown_oe <= 1'b0;
        else
            fault_shutdown_oe <= user_shutdown;
    end

    // fault clear request is remembered until served; a new request wins over the clear
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            clear_pend <= 1'b0;
        else if (user_clear)
            clear_pend <= 1'b1;
        else if (state == ST_CLEARING)
            clear_pend <= 1'b0;
    end

    // sequence and pin drive; the clear pin is high through all of start-up so
    // spurious diagnostics are suppressed, and then only for bounded pulses
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state          <= ST_SUPPLY;
            timer          <= '0;
            drv_pins.high  <= `HBF_RST_HIGH;
            drv_pins.low   <= `HBF_RST_LOW;
            drv_pins.clear <= `HBF_RST_CLEAR;
        end
        else
        begin
            case (state)
                ST_SUPPLY:
                begin
                    drv_pins.clear <= 1'b1;
                    drv_pins.high  <= 1'b0;
                    drv_pins.low   <= 1'b0;
                    timer          <= '0;
                    if (supply_s)
                        state <= ST_CLR_LEAD;
                end
                ST_CLR_LEAD:
                begin
                    // clear is already high; start the bootstrap charge pulse
                    drv_pins.low <= 1'b1;
                    timer        <= '0;
                    state        <= ST_CHARGE;
                end
                ST_CHARGE:
                begin
                    if (timer == PULSE_LAST)
                    begin
                        drv_pins.low <= 1'b0;
                        timer        <= '0;
                        state        <= ST_CLR_TAIL;
                    end
                    else
                        timer <= timer + 1'b1;
                end
                ST_CLR_TAIL:
                begin
                    // clear falls only after the low side has been released
                    drv_pins.clear <= 1'b0;
                    state          <= ST_RUN;
                end
                ST_RUN:
                begin
                    // both commands high would be refused by the driver; keep both off here too
                    drv_pins.high <= user_high & ~user_low;
                    drv_pins.low  <= user_low & ~user_high;
                    timer         <= '0;
                    // no clear while a peer runs soft turn-off on the sync line
                    if (clear_pend && sync_s)
                    begin
                        drv_pins.clear <= 1'b1;
                        state          <= ST_CLEARING;
                    end
                end
                ST_CLEARING:
                begin
                    drv_pins.high <= user_high & ~user_low;
                    drv_pins.low  <= user_low & ~user_high;
                    if (timer == PULSE_LAST)
                    begin
                        drv_pins.clear <= 1'b0;
                        state          <= ST_RUN;
                    end
                    else
                        timer <= timer + 1'b1;
                end
                default:
                begin
                    state          <= ST_SUPPLY;
                    drv_pins.clear <= 1'b1;
                end
            endcase
        end
    end

    // user-side status, all registered
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            status <= '0;
        else
        begin
            status.ready       <= (state == ST_RUN) || (state == ST_CLEARING);
            status.fault_seen  <= ~fsd_s;
            status.freeze_seen <= ~sync_s;
            status.clear_busy  <= (state == ST_CLEARING);
        end
    end

    // shutdown request reaches the pin in one cycle, pulling low
    a_shutdown_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
        user_shutdown |=> (fault_shutdown_oe && !fault_shutdown_out))
        else $error("shutdown request did not pull the line low");

    // line is released one cycle after the request drops
    a_wired_release: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !user_shutdown |=> !fault_shutdown_oe)
        else $error("shutdown line not released");

    // clear pulse in normal mode starts only with the sync line high
    a_clear_vs_sync: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ($rose(drv_pins.clear) && $past(state) == ST_RUN) |-> $past(sync_s))
        else $error("fault clear raised while sync line low");

    // clear is low throughout normal running outside a clear pulse
    a_clear_bounded: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state == ST_RUN && $past(state) == ST_RUN) |-> !drv_pins.clear)
        else $error("fault clear left high in normal mode");

    // start-up waits with clear high and gates off
    a_startup_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state == ST_SUPPLY && $past(state) == ST_SUPPLY)
            |-> (drv_pins.clear && !drv_pins.low && !drv_pins.high))
        else $error("start-up hold state wrong");

    // charge pulse only under an active clear, then low falls before clear
    a_boot_order: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(drv_pins.low) && $past(state) == ST_CHARGE
            |-> drv_pins.clear ##1 !drv_pins.clear)
        else $error("bootstrap order broken");

    // low-side charge pulse lasted the full count
    a_pulse_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ($fell(drv_pins.low) && $past(state) == ST_CHARGE) |-> $past(timer) == PULSE_LAST)
        else $error("start-up pulse too short");

    // in normal mode the gate pins follow the commands one cycle later
    a_run_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state == ST_RUN) |=> (drv_pins.high == ($past(user_high) & ~$past(user_low))
            && drv_pins.low == ($past(user_low) & ~$past(user_high))))
        else $error("gate pins do not follow commands");

endmodule

/* logic/hbf_params.svh */
// timing and field constants for the half-bridge driver controller
// assumes a 40 MHz system clock; included by bare name
`ifndef HBF_PARAMS_SVH
`define HBF_PARAMS_SVH

// system clock period in ns (40 MHz)
`define HBF_CLK_PERIOD_NS   25
// least width of the start-up low-side and clear pulses, in ns
`define HBF_PULSE_MIN_NS    15000
// least pulse as whole clock cycles, rounded up
`define HBF_PULSE_CYCLES    ((`HBF_PULSE_MIN_NS + `HBF_CLK_PERIOD_NS - 1) / `HBF_CLK_PERIOD_NS)
// width of the sequence timer
`define HBF_TIMER_W         10
// bit positions of the synchronised pin inputs
`define HBF_IN_SUPPLY       0
`define HBF_IN_SYNC         1
`define HBF_IN_FSD          2
`define HBF_IN_COUNT        3
// reset values of the driven pins
`define HBF_RST_HIGH        1'h0
`define HBF_RST_LOW         1'h0
`define HBF_RST_CLEAR       1'h1

`endif

/* logic/hbf_pkg.sv */
// types shared by the half-bridge driver controller
// assumes hbf_params.svh for the numeric constants
package hbf_pkg;

    // logic inputs of the gate driver, driven by this controller
    typedef struct packed {
        logic high;   // high_side_input
        logic low;    // low_side_input
        logic clear;  // fault_clear_input
    } hbf_pins_t;

    // start-up and operating sequence
    typedef enum logic [2:0] {
        ST_SUPPLY   = 3'b000,
        ST_CLR_LEAD = 3'b001,
        ST_CHARGE   = 3'b010,
        ST_CLR_TAIL = 3'b011,
        ST_RUN      = 3'b100,
        ST_CLEARING = 3'b101
    } hbf_state_t;

    // status seen by the user side
    typedef struct packed {
        logic ready;       // normal mode reached
        logic fault_seen;  // shared shutdown line is low
        logic freeze_seen; // shared sync-fault line is low
        logic clear_busy;  // a fault clear pulse is in progress
    } hbf_status_t;

endpackage

/* logic/hbf_sync.sv */
// two-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to sys_clk; only the second stage is read
`timescale 1ns/100ps
module hbf_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    // reset to all-ones: every synchronised pin is idle high
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            stage1   <= {W{1'b1}};
            sync_out <= {W{1'b1}};
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

/* test/hbf_drv_model.sv */
// behavioural half-bridge gate driver seen from its logic pins
// assumes the bench resolves the open-drain shared lines with pull-ups
`timescale 1ns/100ps
module hbf_drv_model #(
    parameter int SOFT_NS = 1000
) (
    input  wire logic high_in,
    input  wire logic low_in,
    input  wire logic clear_in,
    input  wire logic sd_line,
    input  wire logic sync_line,
    input  wire logic desat,
    input  wire logic uv_low,
    input  wire logic uv_float,
    output logic      high_gate,
    output logic      low_gate,
    output logic      sync_pull,
    output logic      sd_pull
);
    logic latched;
    logic hs_armed;

    // power-up: nothing latched, both gates off
    initial
    begin
        latched = 1'h0;
        hs_armed = 1'h1;
        sync_pull = 1'h0;
        high_gate = 1'h0;
        low_gate = 1'h0;
    end

    // soft turn-off runs a fixed span; a held clear stops the latch
    always @(posedge desat)
    begin
        sync_pull = 1'h1;
        #(SOFT_NS);
        sync_pull = 1'h0;
        if (!clear_in) latched = 1'h1;
    end

    // clear drops only the latch, never an outside or supply shutdown
    always @(posedge clear_in) latched = 1'h0;
    assign sd_pull = latched | uv_low;

    // floating-supply undervoltage disarms the high gate until a fresh rising command
    always @(posedge uv_float) hs_armed = 1'h0;
    always @(posedge high_in) if (!uv_float) hs_armed = 1'h1;

    // every input change re-evaluates; own soft turn-off or a low shutdown line forces the gates off, else a low sync line holds them
    always @*
    begin
        if (sync_pull)
        begin
            high_gate = 1'h0;
            low_gate = 1'h0;
        end
        else if (!sd_line)
        begin
            high_gate = 1'h0;
            low_gate = 1'h0;
        end
        else if (sync_line)
        begin
            high_gate = high_in & !low_in & hs_armed & !uv_float;
            low_gate = low_in & !high_in;
        end
    end
endmodule

/* test/hbf_ctrl_tb_top.sv */
// self-checking bench for hbf_ctrl against a behavioural gate driver
// assumes pull-ups on both shared lines; PULSE shortens the 15 us pulses
`timescale 1ns/100ps
module hbf_ctrl_tb_top;
    import hbf_pkg::*;
    localparam int PULSE = 4;
    logic        sys_clk, sys_rst, user_high, user_low, user_shutdown, user_clear;
    logic        supply_ok, tb_sd, tb_sync, desat, uv_low, uv_float;
    logic        hg, lg, dev_sync, dev_sd, sd_out, sd_oe;
    hbf_status_t status;
    hbf_pins_t   pins;
    int          errors, total_checks, n, w;
    wire logic   sd_line = ~((sd_oe & ~sd_out) | dev_sd | tb_sd);
    wire logic   sync_line = ~(dev_sync | tb_sync);

    hbf_ctrl #(.PULSE_CYCLES(PULSE)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .user_high(user_high), .user_low(user_low), .user_shutdown(user_shutdown),
        .user_clear(user_clear), .status(status), .drv_pins(pins),
        .supply_ok_pin(supply_ok), .sync_fault_in(sync_line),
        .fault_shutdown_in(sd_line), .fault_shutdown_out(sd_out),
        .fault_shutdown_oe(sd_oe));
    hbf_drv_model drv (.high_in(pins.high), .low_in(pins.low), .clear_in(pins.clear),
        .sd_line(sd_line), .sync_line(sync_line), .desat(desat), .uv_low(uv_low),
        .uv_float(uv_float),
        .high_gate(hg), .low_gate(lg), .sync_pull(dev_sync), .sd_pull(dev_sd));

    // inputs move 2 ns after the edge so nothing races the clock
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #2;
    endtask
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t ns: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // bounded poll of one status bit, then compare it
    task automatic waitbit(input int b, input logic v);
        n = 0;
        while (status[b] !== v && n < 80)
        begin
            step(1);
            n++;
        end
        check(status[b], v);
    endtask
    // waits for a driver pin to rise, then counts its high cycles
    task automatic width(input int b);
        n = 0;
        while (pins[b] !== 1'h1 && n < 60)
        begin
            step(1);
            n++;
        end
        w = 0;
        while (pins[b] === 1'h1 && w < 15)
        begin
            step(1);
            w++;
        end
    endtask
    task automatic conclude;
        $display("checks made %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // 40 MHz system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // watchdog well beyond the 150 or so cycles the tests need
    initial
    begin
        #(25 * 3000);
        errors++;
        $display("wrong value at %0t ns: watchdog expired", $time);
        conclude();
    end

    // test sequence
    initial
    begin
        {sys_rst, user_high, user_low, user_shutdown, user_clear} = 5'h10;
        {supply_ok, tb_sd, tb_sync, desat, uv_low} = 5'h00;
        uv_float = 1'b0;
        errors = 0;
        total_checks = 0;
        repeat (12) @(posedge sys_clk);
        #2 sys_rst = 1'b0;
        step(8);
        check({pins.clear, pins.low, status.ready}, 3'h4);
        supply_ok = 1'b1;
        width(1);
        check(4'(w), 4'(PULSE));
        check(pins.clear, 1'h1);
        step(1);
        check(pins.clear, 1'h0);
        waitbit(3, 1'b1);
        $display("start-up test done");
        for (int i = 0; i < 4; i++)
        begin
            {user_high, user_low} = 2'(i);
            step(2);
            check({pins.high, pins.low, hg, lg}, (i == 1) ? 4'h5 : (i == 2) ? 4'hA : 4'h0);
        end
        $display("gate command test done");
        {user_high, user_low, user_shutdown} = 3'h5;
        step(2);
        check({sd_oe, sd_line, hg, lg}, 4'h8);
        waitbit(2, 1'b1);
        user_shutdown = 1'b0;
        step(2);
        check({sd_oe, sd_line, hg, lg}, 4'h6);
        waitbit(2, 1'b0);
        tb_sd = 1'b1;
        waitbit(2, 1'b1);
        check({sd_oe, hg}, 2'h0);
        tb_sd = 1'b0;
        waitbit(2, 1'b0);
        $display("shutdown test done");
        // freeze: commands move and a clear is asked, but must wait
        tb_sync = 1'b1;
        waitbit(1, 1'b1);
        {user_high, user_low, user_clear} = 3'h3;
        step(1);
        user_clear = 1'b0;
        step(8);
        check({pins.clear, hg, lg}, 3'h2);
        tb_sync = 1'b0;
        width(0);
        check(4'(w), 4'(PULSE));
        check({hg, lg}, 2'h1);
        $display("freeze test done");
        {user_high, user_low} = 2'h2;
        step(2);
        desat = 1'b1;
        step(1);
        desat = 1'b0;
        waitbit(1, 1'b1);
        check({hg, lg}, 2'h0);
        waitbit(2, 1'b1);
        step(10);
        check({status.fault_seen, pins.clear, hg, lg}, 4'h8);
        user_clear = 1'b1;
        step(1);
        user_clear = 1'b0;
        waitbit(0, 1'b1);
        waitbit(2, 1'b0);
        check({hg, lg}, 2'h2);
        $display("desaturation test done");
        uv_low = 1'b1;
        waitbit(2, 1'b1);
        check({hg, lg}, 2'h0);
        uv_low = 1'b0;
        waitbit(2, 1'b0);
        $display("undervoltage test done");
        // floating supply: high gate drops, and comes back only on a new rising command
        uv_float = 1'b1;
        step(2);
        check({pins.high, hg, lg}, 3'h4);
        uv_float = 1'b0;
        step(2);
        check({hg, lg}, 2'h0);
        user_high = 1'b0;
        step(2);
        user_high = 1'b1;
        step(2);
        check({hg, lg}, 2'h2);
        $display("floating undervoltage test done");
        conclude();
    end
endmodule
